// ### logic/capture_pkg.sv
// Purpose: constants and types shared by the capture unit and its software end
// Assumes: one 20 MHz system clock, synchronous active-low reset
// Notes:
package capture_pkg;
    localparam int unsigned CNT_W         = 16;
    localparam int unsigned BYTE_W        = 8;
    localparam int unsigned FILTER_LEN    = 4;
    localparam int unsigned SYNC_LEN      = 3;
    localparam logic [1:0]  SEL_T0_INST   = 2'h0;
    localparam logic [1:0]  SEL_T0_ACC    = 2'h1;
    localparam logic [1:0]  SEL_T1_PIN    = 2'h0;
    localparam logic [1:0]  SEL_T1_RX     = 2'h1;
    localparam logic [1:0]  SEL_T1_TX     = 2'h2;
    localparam logic [1:0]  SEL_RESET     = 2'h0;
    localparam logic        EDGE_FALLING  = 1'b0;
    localparam logic        EDGE_RISING   = 1'b1;
    localparam logic [7:0]  BYTE_RESET    = 8'h00;
    typedef enum logic [1:0]
    {
        SW_IDLE  = 2'b00,
        SW_READ  = 2'b01,
        SW_FLIP  = 2'b11,
        SW_CLEAR = 2'b10
    } sw_state_type;
endpackage : capture_pkg

// ### logic/capture_if.sv
`timescale 1ns/1ns
`default_nettype none
// Purpose: joins the capture unit and the software end
// Assumes: both ends on clk
// Notes: control bits flow from software, state back to it
interface capture_if
    import capture_pkg::*;
(
    input wire logic clk
);
    logic [1:0]        capture_source_select;
    logic              noise_filter_enable;
    logic              edge_polarity_select;
    logic              capture_irq_enable;
    logic              mode_16bit;
    logic              flag_clear_write;
    logic              irq_serviced;
    logic              cmp_b_write;
    logic [BYTE_W-1:0] cmp_b_wdata;
    logic              pin_seven_out;
    logic              pin_seven_drive_n;
    logic [BYTE_W-1:0] compare_reg_a;
    logic [BYTE_W-1:0] compare_reg_b;
    logic              capture_flag;
    logic              capture_irq;
    logic              compare_b_match;
    modport device
    (
        input  capture_source_select, noise_filter_enable,
        input  edge_polarity_select, capture_irq_enable, mode_16bit,
        input  flag_clear_write, irq_serviced, cmp_b_write, cmp_b_wdata,
        input  pin_seven_out, pin_seven_drive_n,
        output compare_reg_a, compare_reg_b, capture_flag, capture_irq,
        output compare_b_match
    );
    modport host
    (
        output capture_source_select, noise_filter_enable,
        output edge_polarity_select, capture_irq_enable, mode_16bit,
        output flag_clear_write, irq_serviced, cmp_b_write, cmp_b_wdata,
        output pin_seven_out, pin_seven_drive_n,
        input  compare_reg_a, compare_reg_b, capture_flag, capture_irq,
        input  compare_b_match
    );
endinterface : capture_if
`default_nettype wire

// ### logic/capture_unit.sv
`timescale 1ns/1ns
`default_nettype none
// Purpose: input capture unit for one timer (timer 0 or timer 1)
// Assumes: counter and event sources on clk; pin is asynchronous
// Notes: TIMER_ID selects the source table
module capture_unit
    import capture_pkg::*;
#(
    parameter int unsigned TIMER_ID = 0
)
(
    input  wire logic             clk,
    input  wire logic             nrst,
    capture_if.device             bus,
    input  wire logic [CNT_W-1:0] counter_value,
    input  wire logic             capture_input_pin,
    input  wire logic             conv_inst_done,
    input  wire logic             conv_acc_done,
    input  wire logic             lin_rx_done,
    input  wire logic             lin_tx_done
);
    logic [SYNC_LEN-1:0]   sync_reg;
    logic                  pin_level;
    logic                  pin_level_reg;
    logic                  pin_seen;
    logic                  src_next;
    logic [FILTER_LEN-2:0] hist_reg;
    logic                  filt_reg;
    logic                  filt_in;
    logic                  det_in;
    logic                  det_prev_reg;
    logic                  trigger;
    logic                  flag_reg;
    logic [BYTE_W-1:0]     cap_a_reg;
    logic [BYTE_W-1:0]     cap_b_reg;
    logic                  match_reg;

    // pin seven output driven by software loops back here
    assign pin_seen = bus.pin_seven_drive_n ? capture_input_pin
                                            : bus.pin_seven_out;

    always_ff @(posedge clk)
    begin
        if (!nrst)
            sync_reg <= '0;
        else
            sync_reg <= {sync_reg[SYNC_LEN-2:0], pin_seen};
    end

    // level accepted only when stages two and three agree
    assign pin_level = (sync_reg[1] == sync_reg[2]) ? sync_reg[1]
                                                     : pin_level_reg;

    always_ff @(posedge clk)
    begin
        if (!nrst)
            pin_level_reg <= 1'b0;
        else
            pin_level_reg <= pin_level;
    end

    // events are one-cycle pulses from logic on clk, so no sync
    always_comb
    begin
        src_next = 1'b0;
        if (TIMER_ID == 0)
        begin
            unique case (bus.capture_source_select)
                SEL_T0_INST: src_next = conv_inst_done;
                SEL_T0_ACC:  src_next = conv_acc_done;
                default:     src_next = 1'b0;
            endcase
        end
        else
        begin
            unique case (bus.capture_source_select)
                SEL_T1_PIN: src_next = pin_level;
                SEL_T1_RX:  src_next = lin_rx_done;
                SEL_T1_TX:  src_next = lin_tx_done;
                default:    src_next = 1'b0;
            endcase
        end
    end

    // filter runs every system clock, no prescaler
    always_ff @(posedge clk)
    begin
        if (!nrst)
            hist_reg <= '0;
        else
            hist_reg <= {hist_reg[FILTER_LEN-3:0], src_next};
    end

    // live input is the fourth sample, so the delay is exactly four
    always_ff @(posedge clk)
    begin
        if (!nrst)
            filt_reg <= 1'b0;
        else if (&{hist_reg, src_next})
            filt_reg <= 1'b1;
        else if (~|{hist_reg, src_next})
            filt_reg <= 1'b0;
    end

    assign filt_in = bus.noise_filter_enable ? filt_reg : src_next;
    // same detector for both timers; filter path only when on
    assign det_in  = filt_in;

    always_ff @(posedge clk)
    begin
        if (!nrst)
            det_prev_reg <= 1'b0;
        else
            det_prev_reg <= det_in;
    end

    // a source switch can make an edge here; software clears
    assign trigger = (bus.edge_polarity_select == EDGE_RISING)
                   ? (det_in & ~det_prev_reg)
                   : (~det_in & det_prev_reg);

    // overwrites whatever was there, read or not
    always_ff @(posedge clk)
    begin
        if (!nrst)
            cap_a_reg <= BYTE_RESET;
        else if (trigger)
            cap_a_reg <= counter_value[BYTE_W-1:0];
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            cap_b_reg <= BYTE_RESET;
        else if (trigger && bus.mode_16bit)
            cap_b_reg <= counter_value[CNT_W-1:BYTE_W];
        else if (bus.cmp_b_write && !bus.mode_16bit)
            cap_b_reg <= bus.cmp_b_wdata;
    end

    // compare B live only in 8-bit capture mode
    always_ff @(posedge clk)
    begin
        if (!nrst)
            match_reg <= 1'b0;
        else
            match_reg <= !bus.mode_16bit
                      && counter_value[BYTE_W-1:0] == cap_b_reg;
    end

    // set wins over clear
    always_ff @(posedge clk)
    begin
        if (!nrst)
            flag_reg <= 1'b0;
        else if (trigger)
            flag_reg <= 1'b1;
        else if (bus.flag_clear_write || bus.irq_serviced)
            flag_reg <= 1'b0;
    end

    // on-chip sources keep their own irq; this one is extra
    always_ff @(posedge clk)
    begin
        if (!nrst)
            bus.capture_irq <= 1'b0;
        else
            bus.capture_irq <= (flag_reg | trigger)
                             & bus.capture_irq_enable
                             & ~(bus.irq_serviced & ~trigger);
    end

    assign bus.compare_reg_a   = cap_a_reg;
    assign bus.compare_reg_b   = cap_b_reg;
    assign bus.capture_flag    = flag_reg;
    assign bus.compare_b_match = match_reg;
endmodule : capture_unit
`default_nettype wire

// ### logic/capture_host.sv
`timescale 1ns/1ns
`default_nettype none
// Purpose: software-side end driving the capture unit controls
// Assumes: user issues one-cycle command pulses
// Notes: auto_duty runs the read / flip / clear sequence
module capture_host
    import capture_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              nrst,
    capture_if.host                bus,
    input  wire logic [1:0]        cfg_source,
    input  wire logic              cfg_filter,
    input  wire logic              cfg_rising,
    input  wire logic              cfg_irq_en,
    input  wire logic              cfg_16bit,
    input  wire logic              cfg_load,
    input  wire logic              clear_req,
    input  wire logic              auto_duty,
    input  wire logic              service_req,
    input  wire logic              pin_out,
    input  wire logic              pin_drive,
    output var  logic [CNT_W-1:0]  read_value,
    output var  logic              read_valid
);
    sw_state_type      state_reg;
    logic [1:0]        src_reg;
    logic              filt_reg;
    logic              pol_reg;
    logic              ien_reg;
    logic              m16_reg;
    logic              clr_reg;
    logic              srv_reg;
    logic              pout_reg;
    logic              pdrv_n_reg;

    always_ff @(posedge clk)
    begin
        if (!nrst)
            state_reg <= SW_IDLE;
        else
            unique case (state_reg)
                // a clear still in flight must not restart the sequence
                SW_IDLE:  if (auto_duty && bus.capture_flag
                              && !bus.flag_clear_write)
                              state_reg <= SW_READ;
                SW_READ:  state_reg <= SW_FLIP;
                SW_FLIP:  state_reg <= SW_CLEAR;
                SW_CLEAR: state_reg <= SW_IDLE;
            endcase
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            src_reg  <= SEL_RESET;
            filt_reg <= 1'b0;
            pol_reg  <= EDGE_FALLING;
            ien_reg  <= 1'b0;
            m16_reg  <= 1'b0;
        end
        else if (cfg_load)
        begin
            src_reg  <= cfg_source;
            // filter kept off for on-chip event sources
            filt_reg <= cfg_filter && cfg_source == SEL_T1_PIN;
            pol_reg  <= cfg_rising;
            ien_reg  <= cfg_irq_en;
            m16_reg  <= cfg_16bit;
        end
        else if (state_reg == SW_FLIP)
            pol_reg <= ~pol_reg;
    end

    // after a source change the stale flag is cleared
    always_ff @(posedge clk)
    begin
        if (!nrst)
            clr_reg <= 1'b0;
        else
            clr_reg <= clear_req || cfg_load
                    || state_reg == SW_CLEAR;
    end

    // either irq order is fine: only capture_irq is consulted, not the flag
    always_ff @(posedge clk)
    begin
        if (!nrst)
            srv_reg <= 1'b0;
        else
            srv_reg <= service_req && bus.capture_irq;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            pout_reg   <= 1'b0;
            pdrv_n_reg <= 1'b1;
        end
        else
        begin
            pout_reg   <= pin_out;
            pdrv_n_reg <= ~pin_drive;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            read_value <= '0;
            read_valid <= 1'b0;
        end
        else
        begin
            read_valid <= state_reg == SW_READ
                       || (service_req && bus.capture_irq);
            if (state_reg == SW_READ || (service_req && bus.capture_irq))
                read_value <= {(m16_reg ? bus.compare_reg_b : BYTE_RESET),
                               bus.compare_reg_a};
        end
    end

    assign bus.capture_source_select = src_reg;
    assign bus.noise_filter_enable   = filt_reg;
    assign bus.edge_polarity_select  = pol_reg;
    assign bus.capture_irq_enable    = ien_reg;
    assign bus.mode_16bit            = m16_reg;
    assign bus.flag_clear_write      = clr_reg;
    assign bus.irq_serviced          = srv_reg;
    assign bus.cmp_b_write           = 1'b0;
    assign bus.cmp_b_wdata           = BYTE_RESET;
    assign bus.pin_seven_out         = pout_reg;
    assign bus.pin_seven_drive_n     = pdrv_n_reg;
endmodule : capture_host
`default_nettype wire

// ### testbench/capture_props.sv
// Purpose: timing checks on the capture interface signals
// Assumes: one clock, nrst synchronous active low
// Notes: compare B write is tied off by the software end
`timescale 1ns/1ns
`default_nettype none
module capture_props
    import capture_pkg::*;
(
    input wire logic              clk,
    input wire logic              nrst,
    input wire logic [1:0]        capture_source_select,
    input wire logic              noise_filter_enable,
    input wire logic              capture_irq_enable,
    input wire logic              mode_16bit,
    input wire logic              flag_clear_write,
    input wire logic              irq_serviced,
    input wire logic [BYTE_W-1:0] compare_reg_a,
    input wire logic [BYTE_W-1:0] compare_reg_b,
    input wire logic              capture_flag,
    input wire logic              capture_irq,
    input wire logic              compare_b_match
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_SRC_RESET: assert property ($rose(nrst) |->
        capture_source_select == SEL_RESET) else $error("source not default");
    AST_FLAG_HOLD: assert property (capture_flag && !flag_clear_write
        && !irq_serviced |=> capture_flag) else $error("flag dropped alone");
    AST_FLAG_FALL: assert property ($fell(capture_flag) |->
        $past(flag_clear_write) || $past(irq_serviced))
        else $error("flag cleared without cause");
    AST_IRQ_ON: assert property ((capture_flag && capture_irq_enable)[*2]
        |-> capture_irq) else $error("enabled flag gave no irq");
    AST_IRQ_OFF: assert property ((!capture_irq_enable)[*2]
        |-> !capture_irq) else $error("masked irq raised");
    AST_NO_CMP16: assert property (mode_16bit && $past(mode_16bit)
        |-> !compare_b_match) else $error("compare B match in 16-bit mode");
    AST_A_COPY: assert property (!$stable(compare_reg_a)
        |-> capture_flag) else $error("register A moved without flag");
    AST_B_COPY: assert property (!$stable(compare_reg_b)
        |-> capture_flag && $past(mode_16bit))
        else $error("register B moved outside 16-bit capture");
    AST_FILT_OFF: assert property (capture_source_select != SEL_T1_PIN
        |-> !noise_filter_enable) else $error("filter on for on-chip source");

    cover property ($rose(capture_flag) && mode_16bit);
    cover property ($fell(capture_flag) && $past(irq_serviced));
    cover property ($rose(capture_flag) && noise_filter_enable);
endmodule : capture_props
`default_nettype wire

// ### testbench/timer_input_capture_tb.sv
// Purpose: drives both capture ends and checks every capture
// Assumes: unit built as timer 1; counter frozen around each event
// Notes: code 3 is reserved and must never capture
`timescale 1ns/1ns
`default_nettype none
module timer_input_capture_tb
    import capture_pkg::*;
    ;
    logic             clk = 1'b0;
    logic             nrst = 1'b0;
    logic [CNT_W-1:0] cnt = 16'h0000;
    logic             pin_ext = 1'b0;
    logic             rx = 1'b0;
    logic             tx = 1'b0;
    logic [1:0]       src = 2'h0;
    logic             filt = 1'b0;
    logic             rise = 1'b0;
    logic             ien = 1'b0;
    logic             m16 = 1'b0;
    logic             load = 1'b0;
    logic             clr = 1'b0;
    logic             serv = 1'b0;
    logic             pout = 1'b0;
    logic             pdrv = 1'b0;
    logic             auto = 1'b0;
    logic [CNT_W-1:0] rd_value;
    logic             rd_valid;
    int               n_reads = 0;
    int               n0;
    int               cmd;
    logic [7:0]       b0;
    logic             f;
    int               s;
    int               num_errors = 0;
    int               compares = 0;

    always #25 clk = ~clk;

    always @(posedge clk)
        if (rd_valid === 1'b1)
            n_reads <= n_reads + 1;

    capture_if u_capture_if (.clk(clk));
    capture_unit #(.TIMER_ID(1)) u_capture_unit (.clk(clk), .nrst(nrst),
        .bus(u_capture_if), .counter_value(cnt), .capture_input_pin(pin_ext),
        .conv_inst_done(1'b0), .conv_acc_done(1'b0), .lin_rx_done(rx),
        .lin_tx_done(tx));
    capture_host u_capture_host (.clk(clk), .nrst(nrst), .bus(u_capture_if),
        .cfg_source(src), .cfg_filter(filt), .cfg_rising(rise),
        .cfg_irq_en(ien), .cfg_16bit(m16), .cfg_load(load), .clear_req(clr),
        .auto_duty(auto), .service_req(serv), .pin_out(pout),
        .pin_drive(pdrv), .read_value(rd_value), .read_valid(rd_valid));
    capture_props u_capture_props (.clk(clk), .nrst(nrst),
        .capture_source_select(u_capture_if.capture_source_select),
        .noise_filter_enable(u_capture_if.noise_filter_enable),
        .capture_irq_enable(u_capture_if.capture_irq_enable),
        .mode_16bit(u_capture_if.mode_16bit),
        .flag_clear_write(u_capture_if.flag_clear_write),
        .irq_serviced(u_capture_if.irq_serviced),
        .compare_reg_a(u_capture_if.compare_reg_a),
        .compare_reg_b(u_capture_if.compare_reg_b),
        .capture_flag(u_capture_if.capture_flag),
        .capture_irq(u_capture_if.capture_irq),
        .compare_b_match(u_capture_if.compare_b_match));

    task automatic check_eq(input string what, input logic [15:0] exp,
                            input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check_eq

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick

    // 0 loads config, 1 clears flag, 2 services the interrupt
    task automatic pulse(input int k);
        @(posedge clk);
        load <= (k == 0);
        clr <= (k == 1);
        serv <= (k == 2);
        @(posedge clk);
        load <= 1'b0;
        clr <= 1'b0;
        serv <= 1'b0;
        tick(4);
    endtask : pulse

    // code 3 wiggles rx, tx and the external pin (not the host pin output) so a leaky decoder shows up
    task automatic set_lv(input logic v);
        @(posedge clk);
        if (s == 1 || s == 3) rx <= v;
        if (s == 2 || s == 3) tx <= v;
        if (s == 0 && pdrv) pout <= v;
        if (s == 3 || (s == 0 && !pdrv)) pin_ext <= v;
    endtask : set_lv

    // pin driven by the host passes its output register first
    function automatic int lat_of(input int code, input logic fl,
                                  input logic dr);
        return (code == 3) ? 0 : 1 + ((code == 0) ? SYNC_LEN + int'(dr) : 0)
            + (fl ? FILTER_LEN : 0);
    endfunction : lat_of

    task automatic idle(input logic x);
        tick(12);
        check_eq("flag", 16'(x), 16'(u_capture_if.capture_flag));
    endtask : idle

    task automatic catch_ev(input int e, input int lat);
        int n;
        n = 0;
        #1;
        if (e != 0)
            tick(lat + 2);
        while (e == 0 && n < 20 && u_capture_if.capture_flag !== 1'b1)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (e == 0)
            check_eq("latency", 16'(lat),
                16'((u_capture_if.capture_flag === 1'b1) ? n : 0));
        if (e == 0 && lat != 0 && u_capture_if.capture_flag !== 1'b1)
            give_verdict();
    endtask : catch_ev

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    initial
    begin
        void'($urandom(32'h9CC2));
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        tick(2);
        check_eq("src_rst", 16'(SEL_RESET),
            16'(u_capture_if.capture_source_select));
        for (int i = 0; i < 32; i++)
        begin
            s = i % 4;
            @(posedge clk);
            src <= 2'(s);
            filt <= 1'($urandom);
            rise <= 1'($urandom);
            ien <= 1'($urandom);
            m16 <= 1'($urandom);
            pdrv <= 1'($urandom);
            pulse(0);
            tick(12);
            pulse(1);
            check_eq("flag_src", 16'h0000, 16'(u_capture_if.capture_flag));
            f = filt && s == 0;
            b0 = u_capture_if.compare_reg_b;
            // second event lands on an unread capture and must overwrite it
            for (int e = 0; e < 2; e++)
            begin
                if (f && e == 0)
                begin
                    set_lv(1'b1);
                    repeat (2) @(posedge clk);
                    set_lv(1'b0);
                    idle(1'b0);
                end
                @(posedge clk);
                cnt <= CNT_W'($urandom);
                set_lv(1'b1);
                if (rise)
                    catch_ev(e, lat_of(s, f, pdrv));
                else
                    idle(e == 1 && s != 3);
                set_lv(1'b0);
                if (!rise)
                    catch_ev(e, lat_of(s, f, pdrv));
                else
                    idle(s != 3);
            end
            if (s != 3)
            begin
                check_eq("cap_a", 16'(cnt[7:0]),
                    16'(u_capture_if.compare_reg_a));
                check_eq("cap_b", m16 ? 16'(cnt[15:8]) : 16'(b0),
                    16'(u_capture_if.compare_reg_b));
            end
            check_eq("cmp_b_match", 16'(!m16 && cnt[7:0] == b0),
                16'(u_capture_if.compare_b_match));
            check_eq("irq", 16'(ien && s != 3),
                16'(u_capture_if.capture_irq));
            cmd = (ien && $urandom % 2) ? 2 : 1;
            pulse(cmd);
            if (cmd == 2 && s != 3)
                check_eq("read", {(m16 ? cnt[15:8] : 8'h00),
                    cnt[7:0]}, rd_value);
            check_eq("flag_clr", 16'h0000, 16'(u_capture_if.capture_flag));
            $display("test %0d source %0d done", i, s);
        end
        // duty cycle: host reads, flips the edge and clears by itself
        s = 1;
        @(posedge clk);
        src <= 2'h1;
        filt <= 1'b0;
        rise <= 1'b1;
        ien <= 1'b0;
        m16 <= 1'b1;
        auto <= 1'b1;
        pulse(0);
        tick(12);
        n0 = n_reads;
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clk);
            cnt <= CNT_W'($urandom);
            set_lv(1'(k == 0));
            tick(12);
            check_eq("duty_read", cnt, rd_value);
            check_eq("duty_edge", 16'(k == 1),
                16'(u_capture_if.edge_polarity_select));
            check_eq("duty_flag", 16'h0000,
                16'(u_capture_if.capture_flag));
        end
        check_eq("duty_reads", 16'h0002, 16'(n_reads - n0));
        $display("test duty cycle done");
        give_verdict();
    end
endmodule : timer_input_capture_tb
`default_nettype wire
